// *** rtl/regulator_status_flag_bank_regs.svh ***
`ifndef REGULATOR_STATUS_FLAG_BANK_REGS_SVH
`define REGULATOR_STATUS_FLAG_BANK_REGS_SVH

// register indices; byte address is four times the index
`define IDX_LINREG_EVENT_FLAGS 8'h1C
`define IDX_TOP_LEVEL_STATUS 8'h1D
`define IDX_BUCK_CONVERTER_STATUS 8'h1E
`define IDX_LINREG_LIVE_STATUS 8'h1F
`define IDX_LINREG_EVENT_ENABLE 8'h22

// reset values
`define RST_LINREG_EVENT_FLAGS 8'h00
`define RST_TOP_LEVEL_STATUS 8'h00
`define RST_BUCK_CONVERTER_STATUS 8'h00
`define RST_LINREG_LIVE_STATUS 8'h00
`define RST_LINREG_EVENT_ENABLE 8'h00

// linear regulator event flag positions (regulator n at base + 4*n)
`define BIT_LINREG_CURRENT_LIMIT_EVENT 0
`define BIT_LINREG_SHORT_CIRCUIT_EVENT 1
`define BIT_LINREG_POWER_GOOD_EVENT 2
`define MASK_LINREG_EVENT_FLAGS 8'h77

// top level status positions
`define BIT_POWER_GOOD_PIN_STATE 7
`define BIT_SYNC_CLOCK_INVALID_STATE 4
`define BIT_THERMAL_SHUTDOWN_STATE 3
`define BIT_THERMAL_WARNING_STATE 2
`define BIT_INPUT_OVERVOLTAGE_STATE 1

// converter and linear regulator live status positions (unit n at base + 4*n)
`define BIT_UNIT_CURRENT_LIMIT_STATE 0
`define BIT_UNIT_VOLTAGE_INVALID_STATE 2
`define BIT_UNIT_ENABLED_STATE 3

// short-circuit qualification time
`define SHORT_CIRCUIT_TIME_US 1000
`define CLOCK_MHZ 100
`define SHORT_CIRCUIT_CYCLES (`SHORT_CIRCUIT_TIME_US * `CLOCK_MHZ)

`endif

// *** rtl/regulator_status_flag_bank_pkg.sv ***
package regulator_status_flag_bank_pkg;
	// one register byte
	typedef logic [7:0] reg_byte_t;
	// short-circuit qualification counter
	typedef logic [19:0] sc_count_t;
	// per-regulator pair of detector levels
	typedef logic [1:0] unit_pair_t;
endpackage

// *** rtl/regulator_status_flag_bank.sv ***
// How it works
// (R1) linear regulator 1 power-good event sets event bit 6 until written one.
// (R2) regulator 1 short below threshold over 1 ms sets event bit 5; W1C.
// (R3) regulator 1 current limit active latches event bit 4 until written one.
// (R4) linear regulator 0 power-good event sets event bit 2 until written one.
// (R5) regulator 0 short below threshold over 1 ms sets event bit 1; W1C.
// (R6) regulator 0 current limit active latches event bit 0 until written one.
// (R7) top status bit 7 follows the power-good output pin.
// (R8) top status bit 4 reads one while external sync clock is invalid.
// (R9) top status bit 3 reads one while above thermal shutdown level.
// (R10) top status bit 2 reads one while above thermal warning level.
// (R11) top status bit 1 reads one while input is above overvoltage threshold.
// (R12) buck status bits 7 and 3 show converter 1 and 0 enabled.
// (R13) buck status bits 6 and 2 show live voltage invalid, one is invalid.
// (R14) buck status bits 4 and 0 show live current limit active.
// (R15) writing zero keeps event bits; an event during a clear keeps it set.
// (R16) status registers ignore writes; reserved bits read zero.
//
// Local design decision: the APB register port.
`timescale 1ns/1ns
`include "regulator_status_flag_bank_regs.svh"

module regulator_status_flag_bank #(
	parameter int SHORT_CIRCUIT_CYCLES = `SHORT_CIRCUIT_CYCLES
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// linear regulator detectors, index 0 and 1
	input wire logic [1:0] linreg_power_good_event,
	input wire logic [1:0] linreg_below_short_threshold,
	input wire logic [1:0] linreg_current_limit_active,
	input wire logic [1:0] linreg_enabled,
	input wire logic [1:0] linreg_voltage_invalid,
	// top level monitors
	input wire logic power_good_output_pin,
	input wire logic sync_clock_invalid,
	input wire logic thermal_shutdown_state,
	input wire logic thermal_warning_state,
	input wire logic input_overvoltage_state,
	// buck converter monitors, index 0 and 1
	input wire logic [1:0] converter_enabled_state,
	input wire logic [1:0] converter_voltage_invalid_state,
	input wire logic [1:0] converter_current_limit_state,
	// interrupt
	output logic irq
);

	regulator_status_flag_bank_pkg::reg_byte_t linreg_event_flags;
	regulator_status_flag_bank_pkg::reg_byte_t linreg_event_enable;
	regulator_status_flag_bank_pkg::reg_byte_t top_level_status;
	regulator_status_flag_bank_pkg::reg_byte_t buck_converter_status;
	regulator_status_flag_bank_pkg::reg_byte_t linreg_live_status;
	regulator_status_flag_bank_pkg::reg_byte_t event_set;
	regulator_status_flag_bank_pkg::reg_byte_t event_clear;
	regulator_status_flag_bank_pkg::reg_byte_t next_linreg_event_flags;
	regulator_status_flag_bank_pkg::reg_byte_t next_read_byte;
	regulator_status_flag_bank_pkg::unit_pair_t short_circuit_seen;
	logic access;
	logic setup_or_wait;
	logic addr_aligned;
	logic hit_flags;
	logic hit_enable;
	logic hit_top;
	logic hit_buck;
	logic hit_live;
	logic mapped;

	// decode on the byte address; the low two bits must be zero
	assign addr_aligned = (paddr[1:0] == 2'h0);
	assign hit_flags = addr_aligned && ({2'h0, paddr[7:2]} == `IDX_LINREG_EVENT_FLAGS);
	assign hit_top = addr_aligned && ({2'h0, paddr[7:2]} == `IDX_TOP_LEVEL_STATUS);
	assign hit_buck = addr_aligned && ({2'h0, paddr[7:2]} == `IDX_BUCK_CONVERTER_STATUS);
	assign hit_live = addr_aligned && ({2'h0, paddr[7:2]} == `IDX_LINREG_LIVE_STATUS);
	assign hit_enable = addr_aligned && ({2'h0, paddr[7:2]} == `IDX_LINREG_EVENT_ENABLE);
	assign mapped = hit_flags || hit_top || hit_buck || hit_live || hit_enable;

	// one wait state: pready rises in the second access cycle
	assign setup_or_wait = psel && penable && !pready;
	assign access = psel && penable && pready;

	// apb handshake; ready is registered so it comes from a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup_or_wait;
			pslverr <= setup_or_wait && !mapped;
		end
	end

	// read mux; reserved bits are zero in every stored value
	always_comb begin
		next_read_byte = 8'h00;
		if (hit_flags) begin
			next_read_byte = linreg_event_flags;
		end else if (hit_top) begin
			next_read_byte = top_level_status;
		end else if (hit_buck) begin
			next_read_byte = buck_converter_status;
		end else if (hit_live) begin
			next_read_byte = linreg_live_status;
		end else if (hit_enable) begin
			next_read_byte = linreg_event_enable;
		end
	end

	// read data captured in the wait cycle, held valid alongside pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup_or_wait && !pwrite) begin
			prdata <= {24'h00_0000, next_read_byte};
		end
	end

	// per regulator event detection, one copy per linear regulator
	genvar n;
	generate
		for (n = 0; n < 2; n = n + 1) begin : g_linreg
			regulator_status_flag_bank_pkg::sc_count_t low_count;
			// count cycles spent below the short threshold, saturating
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					low_count <= 20'h0_0000;
				end else if (!linreg_below_short_threshold[n]) begin
					low_count <= 20'h0_0000;
				end else if (low_count <= SHORT_CIRCUIT_CYCLES[19:0]) begin
					low_count <= low_count + 20'h0_0001;
				end
			end
			// flag only once the low spell lasts longer than the window
			assign short_circuit_seen[n] = linreg_below_short_threshold[n] &&
				(low_count >= SHORT_CIRCUIT_CYCLES[19:0]); // see (R2) see (R5)
			assign event_set[4*n + `BIT_LINREG_CURRENT_LIMIT_EVENT] =
				linreg_current_limit_active[n]; // see (R3) see (R6)
			assign event_set[4*n + `BIT_LINREG_SHORT_CIRCUIT_EVENT] = short_circuit_seen[n];
			assign event_set[4*n + `BIT_LINREG_POWER_GOOD_EVENT] =
				linreg_power_good_event[n]; // see (R1) see (R4)
			assign event_set[4*n + 3] = 1'b0;
		end
	endgenerate

	// write-one-to-clear; zeros in the write leave bits alone
	assign event_clear = (access && pwrite && hit_flags) ? pwdata[7:0] : 8'h00; // see (R15)
	// the set term wins over a clear in the same cycle
	assign next_linreg_event_flags =
		((linreg_event_flags & ~event_clear) | event_set) & `MASK_LINREG_EVENT_FLAGS; // see (R15) see (R16)

	// sticky event flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			linreg_event_flags <= `RST_LINREG_EVENT_FLAGS;
		end else begin
			linreg_event_flags <= next_linreg_event_flags; // see (R1) see (R2) see (R3) see (R4) see (R5) see (R6)
		end
	end

	// interrupt enable, same layout as the flags; one enables the bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			linreg_event_enable <= `RST_LINREG_EVENT_ENABLE;
		end else if (access && pwrite && hit_enable) begin
			linreg_event_enable <= pwdata[7:0] & `MASK_LINREG_EVENT_FLAGS;
		end
	end

	// level interrupt, registered from the next flag value so it rises in the same cycle as the flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_linreg_event_flags & linreg_event_enable);
		end
	end

	// top level live status; writes never reach it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			top_level_status <= `RST_TOP_LEVEL_STATUS;
		end else begin
			top_level_status <= 8'h00; // see (R16)
			top_level_status[`BIT_POWER_GOOD_PIN_STATE] <= power_good_output_pin; // see (R7)
			top_level_status[`BIT_SYNC_CLOCK_INVALID_STATE] <= sync_clock_invalid; // see (R8)
			top_level_status[`BIT_THERMAL_SHUTDOWN_STATE] <= thermal_shutdown_state; // see (R9)
			top_level_status[`BIT_THERMAL_WARNING_STATE] <= thermal_warning_state; // see (R10)
			top_level_status[`BIT_INPUT_OVERVOLTAGE_STATE] <= input_overvoltage_state; // see (R11)
		end
	end

	// converter and linear regulator live status, unlatched raw levels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buck_converter_status <= `RST_BUCK_CONVERTER_STATUS;
			linreg_live_status <= `RST_LINREG_LIVE_STATUS;
		end else begin
			buck_converter_status <= {
				converter_enabled_state[1], converter_voltage_invalid_state[1], 1'b0,
				converter_current_limit_state[1],
				converter_enabled_state[0], converter_voltage_invalid_state[0], 1'b0,
				converter_current_limit_state[0]}; // see (R12) see (R13) see (R14) see (R16)
			linreg_live_status <= {
				linreg_enabled[1], linreg_voltage_invalid[1], 1'b0, linreg_current_limit_active[1],
				linreg_enabled[0], linreg_voltage_invalid[0], 1'b0, linreg_current_limit_active[0]};
		end
	end

endmodule

// *** testbench/regulator_status_flag_bank_chk.sv ***
`timescale 1ns/1ns
module regulator_status_flag_bank_chk (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// interrupt
	input wire logic irq
);
	// single domain, so one clock and one reset for every property
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
	ready_access_a: assert property (pready |-> psel && penable) else $error("ready outside access");
	one_wait_a: assert property (psel && !penable |=> !pready ##1 pready) else $error("wait count off");
	err_unmapped_a: assert property (pready && !(paddr inside {8'h70, 8'h74, 8'h78, 8'h7C, 8'h88}) |-> pslverr)
		else $error("no error on unmapped address");
	err_mapped_a: assert property (pslverr |-> pready && !(paddr inside {8'h70, 8'h74, 8'h78, 8'h7C, 8'h88}))
		else $error("error on mapped address");
	top_reserved_a: assert property (pready && !pwrite && paddr == 8'h74 |-> prdata[6:5] == 2'h0 && !prdata[0])
		else $error("top reserved bits set");
	buck_reserved_a: assert property (pready && !pwrite && paddr == 8'h78 |-> !prdata[5] && !prdata[1])
		else $error("buck reserved bits set");
	flag_reserved_a: assert property (pready && !pwrite && paddr == 8'h70 |-> !prdata[7] && !prdata[3])
		else $error("flag reserved bits set");
	upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
	// a latched flag keeps irq up until some write has landed
	irq_hold_a: assert property (irq && !(psel && pwrite) && !$past(psel && pwrite) |=> irq)
		else $error("irq dropped without a write");
endmodule

bind regulator_status_flag_bank regulator_status_flag_bank_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// *** testbench/tb.sv ***
`timescale 1ns/1ns
module tb;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd_data;
	logic pready, pslverr, irq, rd_err, pgp = 1'h0, clkbad = 1'h0, tsd = 1'h0, twarn = 1'h0, ovp = 1'h0;
	logic [1:0] pge = 2'h0, bsc = 2'h0, lil = 2'h0, len = 2'h0, linv = 2'h0, cen = 2'h0, cinv = 2'h0, cil = 2'h0;
	int err_count = 0, total_checks = 0;
	// short qualification count keeps the run brief
	regulator_status_flag_bank #(.SHORT_CIRCUIT_CYCLES(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .linreg_power_good_event(pge), .linreg_below_short_threshold(bsc),
		.linreg_current_limit_active(lil), .linreg_enabled(len), .linreg_voltage_invalid(linv),
		.power_good_output_pin(pgp), .sync_clock_invalid(clkbad), .thermal_shutdown_state(tsd),
		.thermal_warning_state(twarn), .input_overvoltage_state(ovp), .converter_enabled_state(cen),
		.converter_voltage_invalid_state(cinv), .converter_current_limit_state(cil), .irq(irq));
	always #5 pclk = ~pclk;
	task automatic report_and_stop;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one apb transfer; an idle edge first so psel is never set twice in one step
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 9);
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 9)
			chk("pready", 32'h0, 32'h1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		apb(1'h0, a, 8'h00);
		chk($sformatf("reg %h", a), rd_data, {24'h0, e});
	endtask
	task automatic t_reset;
		rd(8'h70, 8'h00);
		rd(8'h74, 8'h00);
		rd(8'h78, 8'h00);
		rd(8'h88, 8'h00);
		apb(1'h0, 8'h80, 8'h00);
		chk("unmapped err", {31'h0, rd_err}, 32'h1);
		chk("unmapped data", rd_data, 32'h0);
	endtask
	task automatic t_status;
		@(posedge pclk);
		pgp <= 1'h1;
		clkbad <= 1'h1;
		twarn <= 1'h1;
		ovp <= 1'h1;
		cen <= 2'h2;
		cinv <= 2'h1;
		cil <= 2'h3;
		len <= 2'h3;
		linv <= 2'h1;
		rd(8'h74, 8'h96);
		rd(8'h78, 8'h95);
		rd(8'h7C, 8'h8C);
		pgp <= 1'h0;
		clkbad <= 1'h0;
		tsd <= 1'h1;
		twarn <= 1'h0;
		ovp <= 1'h0;
		cen <= 2'h1;
		cinv <= 2'h2;
		cil <= 2'h0;
		apb(1'h1, 8'h74, 8'hFF);
		rd(8'h74, 8'h08);
		rd(8'h78, 8'h48);
	endtask
	task automatic t_events;
		@(posedge pclk);
		pge <= 2'h3;
		lil <= 2'h3;
		@(posedge pclk);
		pge <= 2'h0;
		lil <= 2'h0;
		rd(8'h70, 8'h55);
		apb(1'h1, 8'h70, 8'h00);
		rd(8'h70, 8'h55);
		apb(1'h1, 8'h88, 8'h04);
		repeat (3) @(posedge pclk);
		chk("irq", {31'h0, irq}, 32'h1);
		apb(1'h1, 8'h70, 8'h04);
		rd(8'h70, 8'h51);
		chk("irq", {31'h0, irq}, 32'h0);
		apb(1'h1, 8'h70, 8'h51);
		rd(8'h70, 8'h00);
	endtask
	task automatic t_short;
		@(posedge pclk);
		bsc <= 2'h2;
		repeat (6) @(posedge pclk);
		bsc <= 2'h0;
		rd(8'h70, 8'h00);
		bsc <= 2'h3;
		repeat (12) @(posedge pclk);
		bsc <= 2'h0;
		rd(8'h70, 8'h22);
		// clear while the limit input stays high: set must win
		lil <= 2'h1;
		apb(1'h1, 8'h70, 8'h23);
		rd(8'h70, 8'h01);
		lil <= 2'h0;
		apb(1'h1, 8'h70, 8'h01);
		rd(8'h70, 8'h00);
	endtask
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		t_reset();
		t_status();
		t_events();
		t_short();
		report_and_stop();
	end
	// watchdog well beyond the roughly 120 cycles the tests need
	initial begin
		#30000;
		err_count++;
		report_and_stop();
	end
endmodule
